// file: tb/aot_arith_timing_chk.sv
`timescale 1ns/1ps

// ----------------------------------------
// Timing checker for the arithmetic block
// ----------------------------------------
module aot_arith_timing_chk
   import aot_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Offer
   input wire logic instValid,
   input wire logic [7:0] firstByte,
   input wire logic instReady,
   // Status and results
   input wire logic execBusy,
   input wire logic execDone,
   input wire aot_op_type opKind,
   input wire logic memOperand,
   input wire logic [CYC_W-1:0] execCycles,
   input wire logic unknownOp
);

   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // Accepted offer at this edge
   wire logic accept;
   assign accept = instValid && instReady;

   // Busy cycles already spent in the current run
   logic [CYC_W-1:0] busyCnt_q;

   // Counter restarts whenever the block idles
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busyCnt_q <= '0;
      end else if (execBusy) begin
         busyCnt_q <= busyCnt_q + 6'h01;
      end else begin
         busyCnt_q <= '0;
      end
   end

   ready_not_busy_a: assert property (instReady == !execBusy)
      else $error("ready does not mirror busy");
   accept_starts_a: assert property (accept |=> execBusy)
      else $error("accepted offer did not start execution");
   done_exact_a: assert property (execBusy |->
      (execDone == (busyCnt_q == execCycles - 6'h01)))
      else $error("done not in the last counted cycle");
   done_then_idle_a: assert property (execDone |=> !execBusy)
      else $error("busy outlived the done cycle");
   result_held_a: assert property (!accept |=>
      $stable(opKind) && $stable(execCycles) && $stable(memOperand))
      else $error("decoded result changed without accept");
   adjust_four_a: assert property (accept &&
      (firstByte inside {8'h37, 8'h3f, 8'h27, 8'h2f})
      |=> execCycles == 6'h04 ##3 execDone)
      else $error("adjust did not take four clocks");
   borrow_two_a: assert property (accept &&
      firstByte[7:1] == 7'b0001110
      |=> opKind == OpBorrowSubAcc && execCycles == 6'h02 ##1 execDone)
      else $error("borrow subtract did not take two clocks");
   acc_cmp_two_a: assert property (accept &&
      firstByte[7:1] == 7'b0011110
      |=> opKind == OpCompareImmAcc ##1 execDone)
      else $error("accumulator compare did not take two clocks");
   unknown_one_a: assert property (accept ##1 unknownOp
      |-> execDone && execCycles == 6'h01)
      else $error("unknown opcode not a single clock");
   product_span_a: assert property ((opKind == OpUnsignedProd)
      && execBusy |-> execCycles inside {[12:28]})
      else $error("product count out of range");

endmodule

// file: tb/test_aot_arith_timing.sv
`timescale 1ns/1ps

module test_aot_arith_timing
   import aot_pkg::*;
;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic instValid = 1'b0;
   logic opSize32 = 1'b0;
   logic [7:0] firstByte = 8'h00;
   logic [7:0] secondByte = 8'h00;
   logic [7:0] thirdByte = 8'h00;
   logic [31:0] multiplierVal = 32'h0;
   logic instReady, execBusy, execDone, memOperand, byteOperand, unknownOp;
   aot_op_type opKind;
   logic [CYC_W-1:0] execCycles;
   logic [3:0] instLength;
   int fails = 0;
   int comparisons = 0;

   // Opcode, then field (bit 3 set means any field)
   localparam logic [11:0] OPS [30] = '{12'h1c8, 12'h1d8, 12'hfe1,
      12'hff1, 12'h488, 12'h4f8, 12'h388, 12'h398, 12'h3a8, 12'h3b8,
      12'h807, 12'h817, 12'h827, 12'h837, 12'h3c8, 12'h3d8, 12'hf63,
      12'hf73, 12'hf64, 12'hf74, 12'hf65, 12'hf75, 12'h378, 12'h3f8,
      12'h278, 12'h2f8, 12'h0f8, 12'h698, 12'h6b8, 12'h908};

   // 100 MHz clock
   always #5 clock = ~clock;

   aot_arith_timing i_dut (.clock(clock), .rst_b(rst_b),
      .instValid(instValid), .firstByte(firstByte),
      .secondByte(secondByte), .thirdByte(thirdByte),
      .opSize32(opSize32), .multiplierVal(multiplierVal),
      .instReady(instReady), .execBusy(execBusy), .execDone(execDone),
      .opKind(opKind), .memOperand(memOperand),
      .byteOperand(byteOperand), .execCycles(execCycles),
      .instLength(instLength), .unknownOp(unknownOp));

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic wrap_up;
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   // Significant length of a magnitude, for early-out timing
   function automatic int bitlen(input logic [31:0] v);
      int n;
      n = 0;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) n = i + 1;
      end
      return n;
   endfunction

   // Low bound plus early-out length, capped at the span
   function automatic int ranged(int low, int span, logic [31:0] m);
      return low + ((bitlen(m) < span) ? bitlen(m) : span);
   endfunction

   function automatic void model(input logic [7:0] b1, b2, b3,
      input logic sz, input logic [31:0] m,
      output aot_op_type k, output int n, output logic mem,
      output logic bo, output int len);
      logic [7:0] rm;
      logic [2:0] fld;
      logic md;
      logic [31:0] mag;
      rm = (b1 == 8'h0f) ? b3 : b2;
      fld = rm[5:3];
      mem = (rm[7:6] != 2'b11);
      // Signed forms time on the magnitude
      mag = m[31] ? -m : m;
      casez (b1)
         8'b0001110?: k = OpBorrowSubAcc;
         8'b1111111?: k = (fld == 3'h1) ? OpMinusOneRm : OpUnknown;
         8'b01001???: k = OpMinusOneReg;
         8'b001110??: k = !mem ? OpCompareRegReg :
            (b1[1] ? OpCompareRegMem : OpCompareMemReg);
         8'b100000??: k = (fld == 3'h7) ? OpCompareImmRm : OpUnknown;
         8'b0011110?: k = OpCompareImmAcc;
         8'b1111011?: k = (fld == 3'h3) ? OpSignFlip :
            (fld == 3'h4) ? OpUnsignedProd :
            (fld == 3'h5) ? OpSignedProdAcc : OpUnknown;
         8'h37: k = OpAsciiFixAdd;
         8'h3f: k = OpAsciiFixSub;
         8'h27: k = OpBcdFixAdd;
         8'h2f: k = OpBcdFixSub;
         8'h0f: k = (b2 == 8'haf) ? OpSignedProdRm : OpUnknown;
         8'b011010?1: k = OpSignedProdImm;
         default: k = OpUnknown;
      endcase
      case (k)
         OpMinusOneRm, OpSignFlip: n = mem ? 6 : 2;
         OpCompareImmRm: n = mem ? 5 : 2;
         OpCompareMemReg: n = 5;
         OpCompareRegMem: n = 6;
         OpAsciiFixAdd, OpAsciiFixSub, OpBcdFixAdd, OpBcdFixSub: n = 4;
         OpUnsignedProd: n = ranged(mem ? 15 : 12, b1[0] ? 13 : 5, m);
         OpSignedProdAcc: n = ranged(mem ? 15 : 12, b1[0] ? 13 : 5, mag);
         OpSignedProdRm: n = ranged(mem ? 15 : 12, sz ? 29 : 13, mag);
         OpSignedProdImm: n = ranged(mem ? 14 : 13, sz ? 29 : 13, mag);
         OpUnknown: n = 1;
         default: n = 2;
      endcase
      // Forms that carry a mode byte
      md = k inside {OpMinusOneRm, OpCompareRegReg, OpCompareMemReg,
         OpCompareRegMem, OpCompareImmRm, OpSignFlip, OpUnsignedProd,
         OpSignedProdAcc, OpSignedProdRm, OpSignedProdImm};
      // Byte flag: size bit clear, never for the register products
      bo = md && !b1[0] && !(k inside {OpSignedProdRm, OpSignedProdImm});
      // Length: opcode bytes, mode byte, immediate; no displacement
      len = ((k == OpSignedProdRm) ? 2 : 1) + md;
      if (k inside {OpBorrowSubAcc, OpCompareImmAcc, OpCompareImmRm,
            OpSignedProdImm}) begin
         len += (b1[0] && !b1[1]) ? (sz ? 4 : 2) : 1;
      end
   endfunction

   // ----------------------------------------
   // One instruction; junk is offered while busy
   // ----------------------------------------
   task automatic run_op(input logic [11:0] e, input logic memSel);
      logic [7:0] rm;
      logic [31:0] m;
      logic sz;
      logic mm;
      aot_op_type k;
      int n;
      int w;
      logic bo;
      int ln;
      rm = {memSel ? 2'($urandom_range(0, 2)) : 2'h3,
            e[3] ? 3'($urandom) : e[2:0], 3'($urandom)};
      // Mostly small multipliers, sometimes full width, either sign
      m = ($urandom_range(0, 3) == 0) ? $urandom : $urandom_range(0, 300);
      m = $urandom_range(0, 1) ? -m : m;
      sz = 1'($urandom);
      instValid <= 1'b1;
      firstByte <= e[11:4];
      secondByte <= (e[11:4] == 8'h0f) ? 8'haf : rm;
      thirdByte <= rm;
      opSize32 <= sz;
      multiplierVal <= m;
      model(e[11:4], (e[11:4] == 8'h0f) ? 8'haf : rm, rm, sz, m, k, n, mm,
            bo, ln);
      #1;
      check("instReady idle", instReady, 1'b1);
      // Bounded wait for ready ahead of the accepting edge
      // Bounded wait, ready looked at settled, away from the edge
      w = 0;
      while (instReady !== 1'b1 && w < 60) begin
         @(posedge clock);
         #1;
         w++;
      end
      if (instReady !== 1'b1) begin
         fails++;
         wrap_up();
      end
      // The accepting edge
      @(posedge clock);
      // Offers made while busy must be refused
      firstByte <= 8'($urandom);
      secondByte <= 8'($urandom);
      thirdByte <= 8'($urandom);
      multiplierVal <= $urandom;
      #1;
      check("opKind", opKind, k);
      check("execCycles", execCycles, n);
      check("unknownOp", unknownOp, k == OpUnknown);
      check("byteOperand", byteOperand, bo);
      check("instLength", instLength, ln);
      if (!(k inside {OpBorrowSubAcc, OpMinusOneReg, OpCompareImmAcc,
            OpAsciiFixAdd, OpAsciiFixSub, OpBcdFixAdd, OpBcdFixSub,
            OpUnknown})) begin
         check("memOperand", memOperand, mm);
      end
      for (int c = 1; c <= n; c++) begin
         if (c > 1) begin
            @(posedge clock);
            #1;
         end
         check("execBusy", execBusy, 1'b1);
         check("execDone", execDone, c == n);
      end
      @(posedge clock);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(97855));
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      // Register forms, then memory forms, twice over
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 30; i++) begin
            run_op(OPS[i], r[0]);
         end
      end
      wrap_up();
   end

endmodule

bind aot_arith_timing aot_arith_timing_chk i_chk (.clock(clock),
   .rst_b(rst_b), .instValid(instValid), .firstByte(firstByte),
   .instReady(instReady), .execBusy(execBusy), .execDone(execDone),
   .opKind(opKind), .memOperand(memOperand), .execCycles(execCycles),
   .unknownOp(unknownOp));

// file: verilog/aot_arith_timing.sv
// What this block does
// - Borrow-subtract immediate from accumulator: two clocks
// - Register compare with register: two clocks
// - Memory-with-register compare: five clocks
// - Register-with-memory compare, direction set: six clocks
// - Immediate compare, field 111: two/five
// - Short immediate compare with accumulator: two clocks
// - Sign flip, field 011: two/six
// - ASCII fix after add: four clocks
// - ASCII fix after subtract: four clocks
// - Decimal fix after add: four clocks
// - Decimal fix after subtract: four clocks
// - Unsigned accumulator product, field 100: ranged
// - Signed accumulator product, field 101: same
// - Escape signed product: 12-41/15-44 doubleword
// - Immediate signed product: 13-26/14-27, 13-42/14-43
`timescale 1ns/1ps

module aot_arith_timing
   import aot_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Instruction offer from the queue
   input wire logic instValid,
   input wire logic [7:0] firstByte,
   input wire logic [7:0] secondByte,
   input wire logic [7:0] thirdByte,
   input wire logic opSize32,
   input wire logic [31:0] multiplierVal,
   output logic instReady,
   // Execution status
   output logic execBusy,
   output logic execDone,
   // Decoded results, held until the next accept
   output aot_op_type opKind,
   output logic memOperand,
   output logic byteOperand,
   output logic [CYC_W-1:0] execCycles,
   output logic [3:0] instLength,
   output logic unknownOp
);

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------

   // Bit length of a value, 0 for zero
   function automatic logic [CYC_W-1:0] bitLength(
      input logic [31:0] val
   );
      logic [CYC_W-1:0] len;
      len = '0;
      for (int i = 0; i < 32; i++) begin
         if (val[i]) begin
            len = CYC_W'(i + 1);
         end
      end
      return len;
   endfunction

   // Lower of two counts
   function automatic logic [CYC_W-1:0] lesser(
      input logic [CYC_W-1:0] a,
      input logic [CYC_W-1:0] b
   );
      return (a < b) ? a : b;
   endfunction

   // Pick the register or memory half of a slash pair
   function automatic logic [CYC_W-1:0] slashPick(
      input logic isMem,
      input logic [CYC_W-1:0] regCount,
      input logic [CYC_W-1:0] memCount
   );
      return isMem ? memCount : regCount;
   endfunction

   // ----------------------------------------
   // Decoder
   // ----------------------------------------
   aot_op_type decKind; // Kind of the offered instruction
   logic decEscaped;    // Two-byte escape form seen

   aot_decode u_decode (
      .firstByte(firstByte),
      .secondByte(secondByte),
      .opKind(decKind),
      .escaped(decEscaped)
   );

   // ----------------------------------------
   // Operand attributes
   // ----------------------------------------
   // Mode/register byte follows the opcode, one byte later if escaped
   wire [7:0] modrmByte = decEscaped ? thirdByte : secondByte;
   // Register operand only when the mode field is all ones
   wire modrmIsMem = modrmByte[7:6] != MOD_REGISTER;
   // Short and single-byte forms never touch memory
   wire hasModrm = (decKind == OpMinusOneRm) ||
                   (decKind == OpCompareRegReg) ||
                   (decKind == OpCompareMemReg) ||
                   (decKind == OpCompareRegMem) ||
                   (decKind == OpCompareImmRm) ||
                   (decKind == OpSignFlip) ||
                   (decKind == OpUnsignedProd) ||
                   (decKind == OpSignedProdAcc) ||
                   (decKind == OpSignedProdRm) ||
                   (decKind == OpSignedProdImm);
   wire isMem = hasModrm && modrmIsMem;
   // Size flag clear means byte operands
   wire sizeBit = firstByte[BIT_SIZE];
   wire isByteOp = !decEscaped && (decKind != OpSignedProdImm) &&
                   hasModrm && !sizeBit;

   // ----------------------------------------
   // Multiplier early-out
   // ----------------------------------------
   // Signed forms finish early on the magnitude, not the raw bits
   wire signedProd = (decKind == OpSignedProdAcc) ||
                     (decKind == OpSignedProdRm) ||
                     (decKind == OpSignedProdImm);
   wire [31:0] magnitude = (signedProd && multiplierVal[31]) ?
                           (~multiplierVal + 32'h00000001) :
                           multiplierVal;
   wire [CYC_W-1:0] sigBits = bitLength(magnitude);

   // Accumulator products: byte span when size flag clear, else word
   wire [CYC_W-1:0] accSpan = sizeBit ? SPAN_WORD : SPAN_BYTE;
   // Escape form: doubleword when the operand size is 32 bits
   wire [CYC_W-1:0] escSpan = opSize32 ? SPAN_DWORD : SPAN_WORD;
   // Immediate form is never a byte operation
   wire [CYC_W-1:0] immSpan = opSize32 ? SPAN_DWORD : SPAN_WORD;

   // Base of each ranged count, register or memory half
   wire [CYC_W-1:0] prodBase =
      slashPick(isMem, CYC_PROD_REG_LO, CYC_PROD_MEM_LO);
   wire [CYC_W-1:0] immBase =
      slashPick(isMem, CYC_IMM_REG_LO, CYC_IMM_MEM_LO);

   // Ranged counts: base plus early-out, never above the top
   wire [CYC_W-1:0] accProdCycles =
      prodBase + lesser(sigBits, accSpan);
   wire [CYC_W-1:0] escProdCycles =
      prodBase + lesser(sigBits, escSpan);
   wire [CYC_W-1:0] immProdCycles =
      immBase + lesser(sigBits, immSpan);

   // ----------------------------------------
   // Cycle count selection
   // ----------------------------------------
   logic [CYC_W-1:0] cyclesSel; // Count for the offered instruction

   // Same figures in real, virtual and protected operation
   always_comb begin
      case (decKind)
         OpBorrowSubAcc: begin
            cyclesSel = CYC_SIMPLE;
         end
         OpMinusOneRm: begin
            cyclesSel = slashPick(isMem, CYC_SIMPLE,
                                  CYC_RMW_MEM);
         end
         OpMinusOneReg: begin
            cyclesSel = CYC_SIMPLE;
         end
         OpCompareRegReg: begin
            cyclesSel = CYC_SIMPLE;
         end
         OpCompareMemReg: begin
            cyclesSel = CYC_CMP_MEM_REG;
         end
         OpCompareRegMem: begin
            cyclesSel = CYC_CMP_REG_MEM;
         end
         OpCompareImmRm: begin
            cyclesSel = slashPick(isMem, CYC_SIMPLE,
                                  CYC_CMP_IMM_MEM);
         end
         OpCompareImmAcc: begin
            cyclesSel = CYC_SIMPLE;
         end
         OpSignFlip: begin
            cyclesSel = slashPick(isMem, CYC_SIMPLE,
                                  CYC_RMW_MEM);
         end
         OpAsciiFixAdd: begin
            cyclesSel = CYC_ADJUST;
         end
         OpAsciiFixSub: begin
            cyclesSel = CYC_ADJUST;
         end
         OpBcdFixAdd: begin
            cyclesSel = CYC_ADJUST;
         end
         OpBcdFixSub: begin
            cyclesSel = CYC_ADJUST;
         end
         OpUnsignedProd: begin
            cyclesSel = accProdCycles;
         end
         OpSignedProdAcc: begin
            cyclesSel = accProdCycles;
         end
         OpSignedProdRm: begin
            cyclesSel = escProdCycles;
         end
         OpSignedProdImm: begin
            cyclesSel = immProdCycles;
         end
         default: begin
            // Not ours: retire in one cycle so the queue moves on
            cyclesSel = CYC_UNKNOWN;
         end
      endcase
   end

   // ----------------------------------------
   // Instruction length
   // ----------------------------------------
   // Opcode plus mode byte plus immediate; displacement not counted,
   // since address forms belong to the address unit
   wire immWide = sizeBit && !firstByte[BIT_SIGN_EXT];
   wire [3:0] immBytes =
      (decKind == OpBorrowSubAcc || decKind == OpCompareImmAcc ||
       decKind == OpCompareImmRm || decKind == OpSignedProdImm) ?
      (immWide ? (opSize32 ? 4'h4 : 4'h2) : 4'h1) : 4'h0;
   wire [3:0] opcBytes = decEscaped ? 4'h2 : 4'h1;
   wire [3:0] modrmBytes = hasModrm ? 4'h1 : 4'h0;
   wire [3:0] lengthSel = opcBytes + modrmBytes + immBytes;

   // ----------------------------------------
   // Handshake
   // ----------------------------------------
   logic timerBusy; // Execution in progress
   logic timerLast; // Final execution cycle

   // One instruction at a time; the queue waits while busy
   assign instReady = !timerBusy;
   wire accept = instValid && instReady;

   aot_timer u_timer (
      .clock(clock),
      .rst_b(rst_b),
      .load(accept),
      .loadCount(cyclesSel),
      .busy(timerBusy),
      .lastCycle(timerLast)
   );

   assign execBusy = timerBusy;
   assign execDone = timerLast;

   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   aot_op_type kind_q;
   logic mem_q;
   logic byte_q;
   logic [CYC_W-1:0] cycles_q;
   logic [3:0] length_q;

   // Capture the decode on accept, hold it through execution
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         kind_q <= OpNone;
         mem_q <= 1'b0;
         byte_q <= 1'b0;
         cycles_q <= '0;
         length_q <= 4'h0;
      end else if (accept) begin
         kind_q <= decKind;
         mem_q <= isMem;
         byte_q <= isByteOp;
         cycles_q <= cyclesSel;
         length_q <= lengthSel;
      end
   end

   assign opKind = kind_q;
   assign memOperand = mem_q;
   assign byteOperand = byte_q;
   assign execCycles = cycles_q;
   assign instLength = length_q;
   assign unknownOp = kind_q == OpUnknown;

endmodule

// file: verilog/aot_decode.sv
`timescale 1ns/1ps

module aot_decode
   import aot_pkg::*;
(
   // Instruction bytes
   input wire logic [7:0] firstByte,
   input wire logic [7:0] secondByte,
   // Decoded result
   output aot_op_type opKind,
   output logic escaped
);

   // ----------------------------------------
   // Field extraction
   // ----------------------------------------
   // Operand field of the byte after a one-byte opcode
   wire [2:0] fieldCode = secondByte[5:3];

   // Pattern matches, one wire each
   wire isBorrowAcc = (firstByte & MSK_SIZE) == OPC_BORROW_ACC;
   wire isMinusRm = (firstByte & MSK_SIZE) == OPC_MINUS_RM;
   wire isMinusReg = (firstByte & MSK_REG_SHORT) == OPC_MINUS_REG;
   wire isCmpRR = (firstByte & MSK_DIR_SIZE) == OPC_CMP_RR;
   wire isCmpImm = (firstByte & MSK_DIR_SIZE) == OPC_CMP_IMM;
   wire isCmpAcc = (firstByte & MSK_SIZE) == OPC_CMP_ACC;
   wire isGroup3 = (firstByte & MSK_SIZE) == OPC_GROUP3;
   wire isProdImm = (firstByte & MSK_SIGN_EXT) == OPC_PROD_IMM;
   wire isProdRm = (firstByte == OPC_ESCAPE) &&
                   (secondByte == OPC_PROD_RM);
   wire isMemForm = secondByte[7:6] != MOD_REGISTER;

   // ----------------------------------------
   // Priority selection
   // ----------------------------------------
   // Patterns do not overlap; the chain only picks one name
   assign opKind =
      isBorrowAcc ? OpBorrowSubAcc :
      (isMinusRm && fieldCode == FLD_MINUS) ? OpMinusOneRm :
      isMinusReg ? OpMinusOneReg :
      (isCmpRR && !isMemForm) ? OpCompareRegReg :
      (isCmpRR && !firstByte[BIT_DIR]) ? OpCompareMemReg :
      isCmpRR ? OpCompareRegMem :
      (isCmpImm && fieldCode == FLD_COMPARE) ? OpCompareImmRm :
      isCmpAcc ? OpCompareImmAcc :
      (isGroup3 && fieldCode == FLD_SIGN_FLIP) ? OpSignFlip :
      (isGroup3 && fieldCode == FLD_UPROD) ? OpUnsignedProd :
      (isGroup3 && fieldCode == FLD_SPROD) ? OpSignedProdAcc :
      (firstByte == OPC_ASCII_ADD) ? OpAsciiFixAdd :
      (firstByte == OPC_ASCII_SUB) ? OpAsciiFixSub :
      (firstByte == OPC_BCD_ADD) ? OpBcdFixAdd :
      (firstByte == OPC_BCD_SUB) ? OpBcdFixSub :
      isProdRm ? OpSignedProdRm :
      isProdImm ? OpSignedProdImm :
      OpUnknown;

   // Escape form moves the mode/register byte one place along
   assign escaped = isProdRm;

endmodule

// file: verilog/aot_pkg.sv
package aot_pkg;

   // ----------------------------------------
   // Instruction kinds
   // ----------------------------------------
   typedef enum logic [4:0] {
      OpNone,
      OpBorrowSubAcc,
      OpMinusOneRm,
      OpMinusOneReg,
      OpCompareRegReg,
      OpCompareMemReg,
      OpCompareRegMem,
      OpCompareImmRm,
      OpCompareImmAcc,
      OpSignFlip,
      OpAsciiFixAdd,
      OpAsciiFixSub,
      OpBcdFixAdd,
      OpBcdFixSub,
      OpUnsignedProd,
      OpSignedProdAcc,
      OpSignedProdRm,
      OpSignedProdImm,
      OpUnknown
   } aot_op_type;

   // ----------------------------------------
   // Opcode patterns and masks
   // ----------------------------------------
   localparam logic [7:0] OPC_BORROW_ACC = 8'h1c;
   localparam logic [7:0] MSK_SIZE = 8'hfe;
   localparam logic [7:0] OPC_MINUS_RM = 8'hfe;
   localparam logic [7:0] OPC_MINUS_REG = 8'h48;
   localparam logic [7:0] MSK_REG_SHORT = 8'hf8;
   localparam logic [7:0] OPC_CMP_RR = 8'h38;
   localparam logic [7:0] MSK_DIR_SIZE = 8'hfc;
   localparam logic [7:0] OPC_CMP_IMM = 8'h80;
   localparam logic [7:0] OPC_CMP_ACC = 8'h3c;
   localparam logic [7:0] OPC_GROUP3 = 8'hf6;
   localparam logic [7:0] OPC_ASCII_ADD = 8'h37;
   localparam logic [7:0] OPC_ASCII_SUB = 8'h3f;
   localparam logic [7:0] OPC_BCD_ADD = 8'h27;
   localparam logic [7:0] OPC_BCD_SUB = 8'h2f;
   localparam logic [7:0] OPC_ESCAPE = 8'h0f;
   localparam logic [7:0] OPC_PROD_RM = 8'haf;
   localparam logic [7:0] OPC_PROD_IMM = 8'h69;
   localparam logic [7:0] MSK_SIGN_EXT = 8'hfd;

   // ----------------------------------------
   // Operand field codes and bit positions
   // ----------------------------------------
   localparam logic [2:0] FLD_MINUS = 3'h1;
   localparam logic [2:0] FLD_SIGN_FLIP = 3'h3;
   localparam logic [2:0] FLD_UPROD = 3'h4;
   localparam logic [2:0] FLD_SPROD = 3'h5;
   localparam logic [2:0] FLD_COMPARE = 3'h7;
   localparam logic [1:0] MOD_REGISTER = 2'h3;
   localparam int BIT_SIZE = 0;
   localparam int BIT_DIR = 1;
   localparam int BIT_SIGN_EXT = 1;

   // ----------------------------------------
   // Clock counts
   // ----------------------------------------
   localparam int CYC_W = 6;
   localparam logic [5:0] CYC_SIMPLE = 6'h02;
   localparam logic [5:0] CYC_RMW_MEM = 6'h06;
   localparam logic [5:0] CYC_CMP_MEM_REG = 6'h05;
   localparam logic [5:0] CYC_CMP_REG_MEM = 6'h06;
   localparam logic [5:0] CYC_CMP_IMM_MEM = 6'h05;
   localparam logic [5:0] CYC_ADJUST = 6'h04;
   localparam logic [5:0] CYC_UNKNOWN = 6'h01;
   localparam logic [5:0] CYC_PROD_REG_LO = 6'h0c;
   localparam logic [5:0] CYC_PROD_MEM_LO = 6'h0f;
   localparam logic [5:0] CYC_IMM_REG_LO = 6'h0d;
   localparam logic [5:0] CYC_IMM_MEM_LO = 6'h0e;
   localparam logic [5:0] SPAN_BYTE = 6'h05;
   localparam logic [5:0] SPAN_WORD = 6'h0d;
   localparam logic [5:0] SPAN_DWORD = 6'h1d;

endpackage

// file: verilog/aot_timer.sv
`timescale 1ns/1ps

module aot_timer
   import aot_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Load side
   input wire logic load,
   input wire logic [CYC_W-1:0] loadCount,
   // Status
   output logic busy,
   output logic lastCycle
);

   // ----------------------------------------
   // Down counter
   // ----------------------------------------
   logic [CYC_W-1:0] remain_q; // Cycles still to run
   logic [CYC_W-1:0] remain_d; // Next count

   // Load wins; otherwise count down to zero and rest there
   assign remain_d = load ? loadCount :
                     (remain_q != '0) ? remain_q - 6'h01 : remain_q;

   // Counter register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         remain_q <= '0;
      end else begin
         remain_q <= remain_d;
      end
   end

   // Busy for exactly the loaded number of cycles
   assign busy = remain_q != '0;
   assign lastCycle = remain_q == 6'h01;

endmodule
